//--- src/diag_adc_pkg.sv
// Package with register map, field layout and carrier types of the block.
// How it works
// (R1) Flag register: bits 8..4 diagnostics, 3..1 inputs.
// (R2) First external input result in bits 11..0.
// (R3) Second external input result in bits 11..0.
// (R4) Temperature result in bits 11..0.
// (R5) Diagnostic multiplexer result in bits 11..0.
// (R6) Measured comparator offset readable, corrects conversions.
// (R7) Offset bypass replaces measured offset in correction.
// (R8) Offset register always shows measured offset.
// (R9) Applied DAC code readable as 16 bits.
// (R10) Raw uncorrected result of every conversion stored.
// (R11) Raw result ignores bypass data.
// (R12) Data bypass substitutes data, skips offset correction.
// (R13) Substituted value stored and used for limits.
// (R14) Both bypasses set: offset wins, data bit cleared.
// (R15) Offset bypass data is two's complement.
// (R16) Host should not set both bypasses together.
// (R17) Bit 13 disables ground sampling, default enabled.
// (R18) Bypass register resets to zero.
// (R19) Limit flag updated per conversion against thresholds.
package diag_adc_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int RES_W  = 12;

    localparam logic [ADDR_W-1:0] ADDR_FLAGS    = 7'h23;
    localparam logic [ADDR_W-1:0] ADDR_EXT_INPUT0     = 7'h24;
    localparam logic [ADDR_W-1:0] ADDR_EXT_INPUT1     = 7'h25;
    localparam logic [ADDR_W-1:0] ADDR_TEMP     = 7'h26;
    localparam logic [ADDR_W-1:0] ADDR_DIAG     = 7'h27;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET   = 7'h28;
    localparam logic [ADDR_W-1:0] ADDR_DAC_CODE = 7'h2c;
    localparam logic [ADDR_W-1:0] ADDR_RAW      = 7'h2d;
    localparam logic [ADDR_W-1:0] ADDR_BYPASS   = 7'h2e;

    localparam int BIT_RESULT_SUB = 15;
    localparam int BIT_OFFSET_SUB = 14;
    localparam int BIT_GND_DIS    = 13;

    localparam logic [DATA_W-1:0] BYPASS_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] BYPASS_WMASK = 16'hefff;

    // Flag bit positions for each channel code.
    localparam int FLAG_EXT_INPUT0 = 1;
    localparam int FLAG_EXT_INPUT1 = 2;
    localparam int FLAG_TEMP = 3;
    localparam int FLAG_REF  = 4;
    localparam int FLAG_PAD  = 5;
    localparam int FLAG_CORE = 6;
    localparam int FLAG_ZTC  = 7;
    localparam int FLAG_OUTPUT_VOLTAGE = 8;
    localparam int NUM_CH    = 8;

    localparam logic [RES_W-1:0] RES_MAX = 12'hfff;

    typedef enum logic [2:0] {
        CH_EXT_INPUT0 = 3'h0,
        CH_EXT_INPUT1 = 3'h1,
        CH_TEMPERATURE = 3'h2,
        CH_REFERENCE  = 3'h3,
        CH_PAD_SUPPLY = 3'h4,
        CH_CORE_SUPPLY = 3'h5,
        CH_ZERO_TC    = 3'h6,
        CH_OUTPUT_VOLTAGE = 3'h7
    } channel_t;

    // One finished conversion from the analog converter.
    typedef struct packed {
        logic              done;
        channel_t          channel;
        logic [RES_W-1:0]  raw;
    } conversion_t;

    // Register access from the serial interface.
    typedef struct packed {
        logic              write;
        logic              read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic [RES_W-1:0] low;
        logic [RES_W-1:0] high;
    } limits_t;

endpackage : diag_adc_pkg

//--- src/diag_adc_result_and_bypass.sv
// Result, limit flag and bypass logic of the diagnostic converter.
`timescale 1ns/1ps
module diag_adc_result_and_bypass
    import diag_adc_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      clk_en,
    // Register access from the serial interface
    input  wire reg_access_t               reg_access,
    output logic [DATA_W-1:0]              reg_rdata,
    output logic                           reg_rvalid,
    // Converter side
    input  wire conversion_t               conversion,
    input  wire logic [RES_W-1:0]          offset_measured,
    input  wire logic [DATA_W-1:0]         dac_code_applied,
    input  wire limits_t [NUM_CH-1:0]      channel_limits,
    output logic                           ground_sample_enable,
    output logic [RES_W-1:0]               offset_in_use
);

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0]  bypass;
    logic [RES_W-1:0]   result [NUM_CH];
    logic [NUM_CH-1:0]  flags;
    logic [RES_W-1:0]   raw_result;
    logic [RES_W-1:0]   offset_seen;
    logic [DATA_W-1:0]  dac_seen;
    logic [RES_W-1:0]   next_result;
    logic [DATA_W-1:0]  next_bypass;
    logic               write_bypass;

    assign write_bypass = reg_access.write && reg_access.addr == ADDR_BYPASS;

    // The result-substitute bit is cleared whenever offset substitute is
    // also set, so software reading back sees which bypass actually acts.
    always_comb begin
        next_bypass = reg_access.wdata & BYPASS_WMASK;
        if (next_bypass[BIT_OFFSET_SUB]) begin
            next_bypass[BIT_RESULT_SUB] = 1'b0; // R14
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bypass <= BYPASS_RESET; // R18
        end else if (clk_en && write_bypass) begin
            bypass <= next_bypass;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ground_sample_enable <= 1'b1;
        end else if (clk_en) begin
            ground_sample_enable <= !bypass[BIT_GND_DIS]; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The correction subtracts the offset; with offset substitute the bypass
    // data is a signed value, so the measured offset is treated the same.
    logic [RES_W-1:0]  offset_sel;
    logic signed [RES_W+1:0] corrected;

    assign offset_sel = bypass[BIT_OFFSET_SUB] ? bypass[RES_W-1:0]
                                               : offset_measured; // R7 R15

    always_comb begin
        corrected = $signed({2'b00, conversion.raw})
                  - $signed({{2{offset_sel[RES_W-1]}}, offset_sel}); // R6
        if (bypass[BIT_RESULT_SUB]) begin
            next_result = bypass[RES_W-1:0]; // R12
        end else if (corrected < 0) begin
            next_result = '0;
        end else if (corrected > $signed({2'b00, RES_MAX})) begin
            next_result = RES_MAX;
        end else begin
            next_result = corrected[RES_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            offset_in_use <= '0;
        end else if (clk_en) begin
            offset_in_use <= offset_sel; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One result slot and one limit flag per channel.
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    result[ch] <= '0;
                    flags[ch]  <= 1'b0;
                end else if (clk_en && conversion.done
                             && conversion.channel == channel_t'(ch)) begin
                    result[ch] <= next_result; // R2 R3 R4 R5 R13
                    flags[ch]  <= next_result < channel_limits[ch].low
                               || next_result > channel_limits[ch].high; // R19
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            raw_result <= '0;
        end else if (clk_en && conversion.done) begin
            raw_result <= conversion.raw; // R10 R11
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            offset_seen <= '0;
            dac_seen    <= '0;
        end else if (clk_en) begin
            offset_seen <= offset_measured; // R8
            dac_seen    <= dac_code_applied; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The diagnostic multiplexer register shows the latest diagnostic
    // channel of any kind; flags are remapped to their documented bits.
    logic [RES_W-1:0]  diag_latest;
    logic [DATA_W-1:0] flag_word;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            diag_latest <= '0;
        end else if (clk_en && conversion.done
                     && conversion.channel >= CH_REFERENCE) begin
            diag_latest <= next_result; // R5
        end
    end

    always_comb begin
        flag_word = '0;
        flag_word[FLAG_EXT_INPUT0] = flags[CH_EXT_INPUT0]; // R1
        flag_word[FLAG_EXT_INPUT1] = flags[CH_EXT_INPUT1];
        flag_word[FLAG_TEMP] = flags[CH_TEMPERATURE];
        flag_word[FLAG_REF]  = flags[CH_REFERENCE];
        flag_word[FLAG_PAD]  = flags[CH_PAD_SUPPLY];
        flag_word[FLAG_CORE] = flags[CH_CORE_SUPPLY];
        flag_word[FLAG_ZTC]  = flags[CH_ZERO_TC];
        flag_word[FLAG_OUTPUT_VOLTAGE] = flags[CH_OUTPUT_VOLTAGE];
    end

    ////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] next_rdata;
    localparam logic [DATA_W-RES_W-1:0] PAD = '0;

    always_comb begin
        if (reg_access.addr == ADDR_FLAGS) begin
            next_rdata = flag_word;
        end else if (reg_access.addr == ADDR_EXT_INPUT0) begin
            next_rdata = {PAD, result[CH_EXT_INPUT0]}; // R2
        end else if (reg_access.addr == ADDR_EXT_INPUT1) begin
            next_rdata = {PAD, result[CH_EXT_INPUT1]}; // R3
        end else if (reg_access.addr == ADDR_TEMP) begin
            next_rdata = {PAD, result[CH_TEMPERATURE]}; // R4
        end else if (reg_access.addr == ADDR_DIAG) begin
            next_rdata = {PAD, diag_latest};
        end else if (reg_access.addr == ADDR_OFFSET) begin
            next_rdata = {PAD, offset_seen}; // R8
        end else if (reg_access.addr == ADDR_DAC_CODE) begin
            next_rdata = dac_seen;
        end else if (reg_access.addr == ADDR_RAW) begin
            next_rdata = {PAD, raw_result}; // R11
        end else if (reg_access.addr == ADDR_BYPASS) begin
            next_rdata = bypass;
        end else begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_access.read;
            if (reg_access.read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_bypass_exclusive: assert property ( // R14
        @(posedge clk) disable iff (reset)
        !(bypass[BIT_RESULT_SUB] && bypass[BIT_OFFSET_SUB]))
        else $error("both bypass bits set");

    a_raw_true: assert property ( // R10
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done |=> raw_result == $past(conversion.raw))
        else $error("raw result not stored");

    a_sub_value: assert property ( // R13
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && bypass[BIT_RESULT_SUB]
        && conversion.channel == CH_EXT_INPUT0
        |=> result[CH_EXT_INPUT0] == $past(bypass[RES_W-1:0]))
        else $error("substitute value not stored");

    a_offset_sel: assert property ( // R7
        @(posedge clk) disable iff (reset)
        clk_en && bypass[BIT_OFFSET_SUB]
        |=> offset_in_use == $past(bypass[RES_W-1:0]))
        else $error("offset substitute not used");

    a_offset_meas: assert property ( // R8
        @(posedge clk) disable iff (reset)
        clk_en |=> offset_seen == $past(offset_measured))
        else $error("measured offset not shown");

    a_gnd_sample: assert property ( // R17
        @(posedge clk) disable iff (reset)
        clk_en ##1 clk_en
        |-> ground_sample_enable == !$past(bypass[BIT_GND_DIS]))
        else $error("ground sampling wrong");

    a_flag_high: assert property ( // R19
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_TEMPERATURE
        && next_result > channel_limits[CH_TEMPERATURE].high
        |=> flag_word[FLAG_TEMP])
        else $error("temperature flag not set");

    a_rdata_pad: assert property ( // R3
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(reg_access.addr) == ADDR_EXT_INPUT1
        |-> reg_rdata[DATA_W-1:RES_W] == '0)
        else $error("upper bits not zero");

    a_flag_low: assert property ( // R19
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_TEMPERATURE
        && next_result < channel_limits[CH_TEMPERATURE].low
        |=> flag_word[FLAG_TEMP])
        else $error("temperature low flag not set");

    a_flag_clear: assert property ( // R19
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_EXT_INPUT0
        && next_result >= channel_limits[CH_EXT_INPUT0].low
        && next_result <= channel_limits[CH_EXT_INPUT0].high
        |=> !flag_word[FLAG_EXT_INPUT0])
        else $error("input flag not cleared");

    a_flag_hold: assert property ( // R19
        @(posedge clk) disable iff (reset)
        !(clk_en && conversion.done
          && conversion.channel == CH_OUTPUT_VOLTAGE)
        |=> $stable(flag_word[FLAG_OUTPUT_VOLTAGE]))
        else $error("output voltage flag changed without conversion");

    a_flag_unused: assert property ( // R1
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(clk_en) && $past(reg_access.addr) == ADDR_FLAGS
        |-> reg_rdata[FLAG_EXT_INPUT0-1] == 1'b0
        && reg_rdata[DATA_W-1:FLAG_OUTPUT_VOLTAGE+1] == '0)
        else $error("unused flag bits not zero");

    a_rvalid_follow: assert property ( // R1
        @(posedge clk) disable iff (reset)
        clk_en |=> reg_rvalid == $past(reg_access.read))
        else $error("read valid does not follow read");

    a_write_priority: assert property ( // R14
        @(posedge clk) disable iff (reset)
        clk_en && write_bypass && reg_access.wdata[BIT_OFFSET_SUB]
        |=> bypass[BIT_OFFSET_SUB] && !bypass[BIT_RESULT_SUB])
        else $error("offset substitute did not take priority");

    a_rdata_raw: assert property ( // R11
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(clk_en) && $past(reg_access.addr) == ADDR_RAW
        |-> reg_rdata == {PAD, $past(raw_result)})
        else $error("raw result read back wrong");

    a_rdata_offset: assert property ( // R8
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(clk_en) && $past(reg_access.addr) == ADDR_OFFSET
        |-> reg_rdata == {PAD, $past(offset_seen)})
        else $error("measured offset read back wrong");

    a_rdata_bypass: assert property ( // R14
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(clk_en) && $past(reg_access.addr) == ADDR_BYPASS
        |-> reg_rdata == $past(bypass))
        else $error("bypass control read back wrong");

    a_rdata_dac: assert property ( // R9
        @(posedge clk) disable iff (reset)
        reg_rvalid && $past(clk_en) && $past(reg_access.addr) == ADDR_DAC_CODE
        |-> reg_rdata == $past(dac_seen))
        else $error("applied code read back wrong");

    a_dac_seen: assert property ( // R9
        @(posedge clk) disable iff (reset)
        clk_en |=> dac_seen == $past(dac_code_applied))
        else $error("applied code not captured");

    a_offset_measured: assert property ( // R6
        @(posedge clk) disable iff (reset)
        clk_en && !bypass[BIT_OFFSET_SUB]
        |=> offset_in_use == $past(offset_measured))
        else $error("measured offset not used");

    a_raw_hold: assert property ( // R10
        @(posedge clk) disable iff (reset)
        !(clk_en && conversion.done) |=> $stable(raw_result))
        else $error("raw result changed without conversion");

    a_raw_unsubst: assert property ( // R11
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && bypass[BIT_RESULT_SUB]
        |=> raw_result == $past(conversion.raw))
        else $error("raw result took substitute data");

    a_diag_ref: assert property ( // R5
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_REFERENCE
        |=> diag_latest == result[CH_REFERENCE])
        else $error("reference result not in diagnostic register");

    a_diag_output_voltage: assert property ( // R5
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_OUTPUT_VOLTAGE
        |=> diag_latest == result[CH_OUTPUT_VOLTAGE])
        else $error("output voltage result not in diagnostic register");

    a_diag_temp: assert property ( // R5
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_TEMPERATURE
        |=> $stable(diag_latest))
        else $error("temperature disturbed diagnostic register");

    a_ext_input0_keep: assert property ( // R2
        @(posedge clk) disable iff (reset)
        clk_en && conversion.done && conversion.channel == CH_EXT_INPUT1
        |=> $stable(result[CH_EXT_INPUT0]))
        else $error("second input disturbed first input result");

endmodule : diag_adc_result_and_bypass

//--- dv/host_model.sv
// Host model that reaches the block registers over the serial interface.
`timescale 1ns/1ps
module host_model
    import diag_adc_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register access toward the block
    output reg_access_t            reg_access,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              reg_rvalid
);
    initial reg_access = '0;

    // Released fields show inverted values so stale data cannot pass.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_access <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_access <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_access <= '{write: 1'b0, read: 1'b1, addr: a, wdata: '0};
        @(negedge clk);
        reg_access <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: '1};
        d = 'x;
        for (int n = 0; n < 4; n++) begin
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
            @(negedge clk);
        end
    endtask : rd
endmodule : host_model

//--- dv/test_diag_adc_result_and_bypass.sv
// Self-checking bench for the converter result and bypass block.
`timescale 1ns/1ps
module test_diag_adc_result_and_bypass;
    import diag_adc_pkg::*;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 clk_en = 1'b1;
    reg_access_t          reg_access;
    logic [DATA_W-1:0]    reg_rdata;
    logic                 reg_rvalid;
    conversion_t          conversion = '0;
    logic [RES_W-1:0]     offset_measured = '0;
    logic [DATA_W-1:0]    dac_code_applied = '0;
    limits_t [NUM_CH-1:0] channel_limits = '0;
    logic                 ground_sample_enable;
    logic [RES_W-1:0]     offset_in_use;
    int                   fails = 0;
    int                   compares = 0;
    int                   res_q[NUM_CH] = '{default: 0};
    int                   flags = 0;
    int                   raw_e = 0;
    int                   diag_e = 0;
    int                   byp = 0;
    logic [DATA_W-1:0]    d;

    always #50 clk = ~clk;

    diag_adc_result_and_bypass DUT (.clk(clk), .reset(reset), .clk_en(clk_en),
        .reg_access(reg_access), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .conversion(conversion), .offset_measured(offset_measured),
        .dac_code_applied(dac_code_applied), .channel_limits(channel_limits),
        .ground_sample_enable(ground_sample_enable),
        .offset_in_use(offset_in_use));
    host_model host (.clk(clk), .reg_access(reg_access),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic test_done;
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input logic [ADDR_W-1:0] a, input int exp);
        host.rd(a, d);
        chk($sformatf("reg %h", a), d, exp[15:0]);
    endtask : rdchk

    function automatic int sx12(input int v);
        return ((v & 'hfff) ^ 'h800) - 'h800;
    endfunction : sx12

    // The model keeps results as integers and clamps them to the code range.
    task automatic convert(input int ch, input int raw);
        int r;
        r = byp[14] ? raw - sx12(byp) : raw - sx12(offset_measured);
        if (byp[15]) r = byp & 'hfff;
        r = (r < 0) ? 0 : (r > 'hfff) ? 'hfff : r;
        res_q[ch] = r;
        raw_e = raw;
        if (ch >= 3) diag_e = r;
        flags[ch+1] = (r < channel_limits[ch].low || r > channel_limits[ch].high);
        @(negedge clk);
        conversion <= '{done: 1'b1, channel: channel_t'(ch), raw: raw[11:0]};
        @(negedge clk);
        conversion <= '{done: 1'b0, channel: channel_t'(ch), raw: ~raw[11:0]};
    endtask : convert

    task automatic check_all;
        rdchk(ADDR_FLAGS, flags);
        rdchk(ADDR_EXT_INPUT0, res_q[0]);
        rdchk(ADDR_EXT_INPUT1, res_q[1]);
        rdchk(ADDR_TEMP, res_q[2]);
        rdchk(ADDR_DIAG, diag_e);
        rdchk(ADDR_OFFSET, offset_measured);
        rdchk(ADDR_DAC_CODE, dac_code_applied);
        rdchk(ADDR_RAW, raw_e);
        rdchk(ADDR_BYPASS, byp);
        chk("ground_sample_enable", ground_sample_enable, !byp[13]);
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #5_000_000;
        fails++;
        test_done();
    end

    initial begin
        int v;
        int raw;
        void'($urandom(32'h859dc796));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        check_all();
        rdchk(7'h30, 0);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            offset_measured = $urandom;
            dac_code_applied = $urandom;
            for (int c = 0; c < NUM_CH; c++) channel_limits[c] = $urandom;
            // Mode 3 sets both bypass bits on purpose to see offset win.
            v = (($urandom % 4) << 14) | ($urandom & 'h3fff);
            host.wr(ADDR_BYPASS, v);
            byp = v & 'hefff;
            if (byp[15] && byp[14]) byp[15] = 1'b0;
            raw = (i % 5 == 0) ? 0 : (i % 5 == 1) ? 'hfff : $urandom & 'hfff;
            convert(i % NUM_CH, raw);
            chk("offset_in_use", offset_in_use,
                byp[14] ? byp & 'hfff : offset_measured);
            check_all();
        end
        // Result registers are read-only, so a write there must be ignored.
        host.wr(ADDR_EXT_INPUT0, 16'h0abc);
        check_all();
        // Freezing the enable must drop a conversion pulse.
        clk_en = 1'b0;
        @(negedge clk);
        conversion <= '{done: 1'b1, channel: CH_EXT_INPUT0, raw: 12'h5a5};
        @(negedge clk);
        conversion <= '{done: 1'b0, channel: CH_EXT_INPUT0, raw: 12'ha5a};
        clk_en = 1'b1;
        check_all();
        // A reset in mid-run clears the bypass and every result again.
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        res_q = '{default: 0};
        {flags, raw_e, diag_e, byp} = '0;
        check_all();
        test_done();
    end
endmodule : test_diag_adc_result_and_bypass
